/* bench/tb_wtm_monitor.sv */
// self-checking bench of the warning and telemetry monitor
`timescale 1ns/1ps
module tb_wtm_monitor import wtm_pkg::*; ;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic vinStb, voutStb, curStb, curNeg, tempStb, gateLow, busFail;
	logic [11:0] vin, vout, cur, extTemp;
	logic [7:0] dieTemp;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic regWr, regRd, warnPin, regOc;
	wtm_ctrl_e ctrlState;
	int mismatches = 0;
	int comparisons = 0;
	localparam logic [7:0] RA [0:9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14,
		8'h18, 8'h1C, 8'h58, 8'h5C, 8'hFC};
	localparam logic [31:0] RV [0:9] = '{32'h0, 32'h1FFF, 32'h1FFF, 32'h0,
		32'h0, 32'h0, 32'hFFFFFF, 32'h0, 32'hFFF, 32'h0};
	always #5 clock = ~clock;
	wtm_monitor i_dut (.clock, .rst_n, .ce(1'b1), .vinStb, .vin, .voutStb,
		.vout, .curStb, .cur, .curNeg, .tempStb, .extTemp,
		.dieTemp, .gateLow, .ctrlState, .regByOvercurrent(regOc), .busFail,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata, .warnPin);
	wtm_host i_host (.clock, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkBit(input int b, input logic e);
		logic [31:0] d;
		i_host.rd(8'h0C, d);
		chk({31'h0, d[b]}, {31'h0, e});
	endtask
	task automatic chkPin(input logic e);
		#1 chk({31'h0, warnPin}, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one strobe per call; the value carries curNeg in bit 12
	task automatic smp(input int k, input logic [12:0] v);
		@(posedge clock);
		{vin, vout, cur, curNeg} <= {v[11:0], v[11:0], v[11:0], v[12]};
		{dieTemp, extTemp} <= {v[7:0], v[11:0]};
		{tempStb, curStb, voutStb, vinStb} <= 4'h1 << k;
		@(posedge clock);
		{tempStb, curStb, voutStb, vinStb} <= 4'h0;
	endtask
	task automatic hyst(input int idx, input int b, input int k,
		input logic [12:0] sv, hv, cv, input logic [23:0] thr, rv);
		if (idx < 9) i_host.wr(8'h18 + 8'(idx * 4), {8'h0, thr});
		smp(k, sv);
		cyc(5);
		chkBit(b, 1'b1);
		chkPin(1'b1);
		smp(k, hv);
		cyc(5);
		i_host.clrStat(32'h1 << b);
		chkBit(b, 1'b1);
		smp(k, cv);
		cyc(5);
		i_host.clrStat(32'h1 << b);
		chkBit(b, 1'b0);
		chkPin(1'b0);
		if (idx < 9) i_host.wr(8'h18 + 8'(idx * 4), {8'h0, rv});
	endtask
	task automatic resetVals;
		logic [31:0] d;
		for (int i = 0; i < 10; i++) begin
			i_host.rd(RA[i], d);
			chk(d, RV[i]);
		end
	endtask
	task automatic gate;
		cyc(1);
		{ctrlState, gateLow} <= {WTM_STANDBY, 1'b1};
		cyc(5);
		chkBit(0, 1'b0);
		cyc(1);
		ctrlState <= WTM_ON;
		cyc(5);
		chkBit(0, 1'b1);
		cyc(1);
		gateLow <= 1'b0;
		cyc(5);
		i_host.clrStat(32'h1);
		chkBit(0, 1'b0);
	endtask
	task automatic lowArm;
		cyc(1);
		ctrlState <= WTM_STANDBY;
		cyc(2);
		ctrlState <= WTM_ON;
		i_host.wr(8'h30, 32'h400);
		smp(2, 13'h100);
		cyc(5);
		chkBit(7, 1'b0);
		smp(2, 13'h500);
	endtask
	// timer field off, on with overcurrent entry, on with another cause
	task automatic regAlert;
		for (int t = 0; t < 3; t++) begin
			i_host.wr(8'h00, (t == 0) ? 32'h0 : 32'h10000);
			regOc <= (t != 2);
			ctrlState <= WTM_IREG;
			cyc(4);
			chkBit(8, t == 1);
			ctrlState <= WTM_ON;
			cyc(3);
			i_host.clrStat(32'h100);
			chkBit(8, 1'b0);
		end
		regOc <= 1'b1;
		i_host.wr(8'h00, 32'h0);
	endtask
	task automatic disabled;
		i_host.wr(8'h04, 32'h1FFD);
		i_host.wr(8'h18, 32'h400);
		smp(0, 13'h100);
		cyc(5);
		chkBit(1, 1'b0);
		i_host.wr(8'h18, 32'h0);
		i_host.wr(8'h04, 32'h1FFF);
	endtask
	task automatic busErr;
		logic [31:0] d;
		cyc(1);
		busFail <= 1'b1;
		cyc(1);
		busFail <= 1'b0;
		cyc(4);
		chkPin(1'b1);
		i_host.wr(8'h08, 32'h0);
		chkPin(1'b0);
		i_host.wr(8'h14, 32'h1);
		i_host.wr(8'h08, 32'h1FFF);
		chkPin(1'b1);
		i_host.clrStat(32'h1000);
		chkPin(1'b0);
		cyc(1);
		{ctrlState, busFail} <= {WTM_LATCHOFF, 1'b1};
		cyc(1);
		busFail <= 1'b0;
		cyc(4);
		i_host.rd(8'h14, d);
		chk(d, 32'h1);
		chkPin(1'b0);
		cyc(1);
		ctrlState <= WTM_ON;
		i_host.wr(8'h10, 32'h1);
		i_host.wr(8'h14, 32'h1);
		chkBit(12, 1'b0);
	endtask
	task automatic average;
		logic [31:0] d;
		for (int s = 0; s < 8; s++) begin
			i_host.wr(8'h00, 32'(s));
			for (int i = 0; i < (1 << s); i++) begin
				if (s > 1 && i == (1 << s) - 1) begin
					i_host.rd(8'h40, d);
					chk(d, 32'h101);
				end
				smp(0, 13'h100 + 13'((i & 1) * 2));
			end
			cyc(2);
			i_host.rd(8'h40, d);
			chk(d, (s == 0) ? 32'h100 : 32'h101);
		end
		i_host.wr(8'h00, 32'h0);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{vinStb, voutStb, curStb, curNeg, tempStb, gateLow, busFail} = '0;
		{vin, vout, cur, dieTemp, extTemp} = '0;
		regOc = 1'b1;
		ctrlState = WTM_ON;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		resetVals;
		gate;
		hyst(1, 2, 0, 13'h400, 13'h3A0, 13'h39F, 24'h400, 24'hFFFFFF);
		hyst(0, 1, 0, 13'h400, 13'h460, 13'h461, 24'h400, 24'h0);
		hyst(3, 4, 1, 13'h400, 13'h460, 13'h461, 24'h400, 24'h0);
		hyst(5, 6, 2, 13'h401, 13'h380, 13'h37F, 24'h400, 24'hFFFFFF);
		lowArm;
		hyst(6, 7, 2, 13'h3FF, 13'h480, 13'h481, 24'h400, 24'h0);
		hyst(8, 9, 2, 13'h1200, 13'h1001, 13'h5, 24'h100, 24'hFFFFFF);
		hyst(9, 11, 3, 13'h7E, 13'h74, 13'h72, 24'h0, 24'h0);
		hyst(7, 10, 3, 13'h401, 13'h3F0, 13'h37D, 24'h400,
			24'hFFFFFF);
		regAlert;
		disabled;
		busErr;
		average;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		stop_test;
	end
endmodule

/* bench/wtm_host.sv */
// host model driving the register port of the monitor
`timescale 1ns/1ps
module wtm_host (
	// clock
	input wire logic clock,
	// register port
	output logic [7:0] regAddr,
	output logic [31:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [31:0] regRdata
);
	initial begin
		{regAddr, regWdata, regWr, regRd} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
		// stale data would hide a slave sampling too late
		regWdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		// data stands for the cycle after the strobe; take it at its end
		@(posedge clock);
		d = regRdata;
	endtask
	// the pin is released through alert status, not bus error status
	task automatic clrStat(input logic [31:0] bits);
		wr(8'h0C, bits);
	endtask
endmodule

/* bench/wtm_monitor_assertions.sv */
// port checker of the warning and telemetry monitor
`timescale 1ns/1ps
module wtm_monitor_assertions import wtm_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// samples and controller
	input wire logic tempStb,
	input wire logic [7:0] dieTemp,
	input wire logic gateLow,
	input wire wtm_ctrl_e ctrlState,
	input wire logic busFail,
	// register port and pin
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic warnPin
);
	// shadow of enable and pin mask, so pin checks only fire when reported
	logic [12:0] enOn_ff;
	logic [12:0] maskOn_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enOn_ff <= 13'h1FFF;
			maskOn_ff <= 13'h1FFF;
		end else if (ce && regWr) begin
			if (regAddr == 8'h04) enOn_ff <= regWdata[12:0];
			if (regAddr == 8'h08) maskOn_ff <= regWdata[12:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_RD_IDLE: assert property ($past(ce) && !$past(regRd) |->
		regRdata == 32'h0) else $error("read data outside answer");
	AST_RD_UNMAP: assert property (ce && regRd && regAddr == 8'hFC |=>
		regRdata == 32'h0) else $error("unmapped read not zero");
	AST_PIN_RESET: assert property ($rose(rst_n) |-> !warnPin)
		else $error("pin high after reset");
	AST_STICKY: assert property (warnPin && !(ce && regWr) |=> warnPin)
		else $error("pin dropped without a clear");
	AST_LATCH_FREEZE: assert property (ce && ctrlState == WTM_LATCHOFF
		|=> $stable(warnPin)) else $error("pin moved in latch-off");
	AST_BUS_PIN: assert property (ce && busFail && enOn_ff[12]
		&& maskOn_ff[12] && ctrlState != WTM_LATCHOFF
		##1 (ce && ctrlState != WTM_LATCHOFF)[*2] |=> warnPin)
		else $error("bus failure missing on pin");
	AST_GATE: assert property ((ce && gateLow && ctrlState == WTM_ON
		&& enOn_ff[0] && maskOn_ff[0])[*4] |=> warnPin)
		else $error("gate-drive alert missing");
	AST_DIE: assert property (ce && tempStb && $signed(dieTemp) > 8'sd125
		&& enOn_ff[11] && maskOn_ff[11] && ctrlState == WTM_ON
		##1 (ce && ctrlState == WTM_ON)[*4] |=> warnPin)
		else $error("die temperature alert missing");
	AST_MASK_NONE: assert property ((ce && maskOn_ff == 13'h0
		&& ctrlState != WTM_LATCHOFF)[*2] |-> !warnPin)
		else $error("pin high with all masked");
endmodule
bind wtm_monitor wtm_monitor_assertions i_chk (.clock, .rst_n, .ce,
	.tempStb, .dieTemp, .gateLow, .ctrlState, .busFail, .regAddr,
	.regWdata, .regWr, .regRd, .regRdata, .warnPin);

/* hw/wtm_monitor.sv */
// warning detection, telemetry averaging and register port of the monitor
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "wtm_regs.svh"
module wtm_monitor import wtm_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// converter samples
	input wire logic vinStb,
	input wire logic [11:0] vin,
	input wire logic voutStb,
	input wire logic [11:0] vout,
	input wire logic curStb,
	input wire logic [11:0] cur,
	input wire logic curNeg,
	input wire logic tempStb,
	input wire logic [11:0] extTemp,
	input wire logic [7:0] dieTemp,
	// controller status
	input wire logic gateLow,
	input wire wtm_ctrl_e ctrlState,
	input wire logic regByOvercurrent,
	input wire logic busFail,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// alert pin
	output logic warnPin
);

	//------------------------------------------------------------------
	// alert bit positions
	//------------------------------------------------------------------
	localparam int A_GATE = 0;
	localparam int A_INLO = 1;
	localparam int A_INHI = 2;
	localparam int A_PWR = 3;
	localparam int A_OUTLO = 4;
	localparam int A_OUTHI = 5;
	localparam int A_CURHI = 6;
	localparam int A_CURLO = 7;
	localparam int A_REG = 8;
	localparam int A_REV = 9;
	localparam int A_TEXT = 10;
	localparam int A_DIE = 11;
	localparam int A_BUS = 12;

	wtm_state_s s;
	wtm_state_s n;

	//------------------------------------------------------------------
	// decoded helpers
	//------------------------------------------------------------------
	logic [3:0] smpStb;
	logic [3:0][23:0] smpVal;
	logic [3:0][2:0] smpSel;
	logic [8:0] pvStb;
	logic [8:0][23:0] pvSrc;
	logic [8:0] pvIsPeak;
	logic [11:0] vinNow;
	logic grpA;
	logic grpB;
	logic grpP;
	logic latched;
	logic thrHit;
	logic pvHit;
	logic [3:0] thrIdx;
	logic [3:0] pvIdx;

	assign vinNow = vinStb ? vin : s.vinRaw;
	assign latched = ctrlState == WTM_LATCHOFF;
	assign grpA = ctrlState inside {WTM_STANDBY, WTM_INIT_REG, WTM_ON,
		WTM_IREG, WTM_FAULT};
	assign grpB = ctrlState inside {WTM_ON, WTM_IREG};
	assign grpP = ctrlState inside {WTM_INIT_REG, WTM_ON, WTM_IREG};
	assign thrHit = regAddr >= `WTM_A_THR && regAddr <= `WTM_A_THR_END;
	assign pvHit = regAddr >= `WTM_A_PV && regAddr <= `WTM_A_PV_END;
	assign thrIdx = 4'((regAddr - `WTM_A_THR) >> 2);
	assign pvIdx = 4'((regAddr - `WTM_A_PV) >> 2);

	// channels: 0 input volt, 1 output volt, 2 current, 3 power
	assign smpStb[0] = vinStb;
	assign smpStb[1] = voutStb;
	assign smpStb[2] = curStb;
	assign smpStb[3] = curStb;
	assign smpVal[0] = {12'h000, vin};
	assign smpVal[1] = {12'h000, vout};
	assign smpVal[2] = {12'h000, cur};
	// power taken on each current sample before any averaging
	assign smpVal[3] = {12'h000, vinNow} * {12'h000, cur};
	// both voltages share one field
	assign smpSel[0] = s.vAvgSel;
	assign smpSel[1] = s.vAvgSel;
	assign smpSel[2] = s.iAvgSel;
	assign smpSel[3] = s.pAvgSel;

	// peak/valley sources follow the averaged results, external temp the raw code
	assign pvStb[0] = s.avgNew[0];
	assign pvStb[1] = s.avgNew[0];
	assign pvStb[2] = s.avgNew[1];
	assign pvStb[3] = s.avgNew[1];
	assign pvStb[4] = s.avgNew[2];
	assign pvStb[5] = s.avgNew[2];
	assign pvStb[6] = s.avgNew[3];
	assign pvStb[7] = s.tempNew;
	assign pvStb[8] = s.tempNew;
	assign pvSrc[0] = s.avg[0];
	assign pvSrc[1] = s.avg[0];
	assign pvSrc[2] = s.avg[1];
	assign pvSrc[3] = s.avg[1];
	assign pvSrc[4] = s.avg[2];
	assign pvSrc[5] = s.avg[2];
	assign pvSrc[6] = s.avg[3];
	assign pvSrc[7] = {12'h000, s.extTemp};
	assign pvSrc[8] = {12'h000, s.extTemp};
	assign pvIsPeak = 9'h0D5;

	//------------------------------------------------------------------
	// next state
	//------------------------------------------------------------------
	always_comb begin
		logic [30:0] sum;
		logic [12:0] det;
		logic [12:0] clr;
		logic [23:0] base;
		sum = '0;
		det = '0;
		clr = '0;
		base = '0;
		n = s;
		n.avgNew = '0;
		n.tempNew = 1'b0;
		n.rdata = '0;
		if (vinStb) begin
			n.vinRaw = vin;
		end

		//--------------------------------------------------------------
		// register writes
		//--------------------------------------------------------------
		if (regWr) begin
			unique case (regAddr)
				`WTM_A_CFG: begin
					n.vAvgSel = regWdata[`WTM_F_VAVG -: 3];
					n.iAvgSel = regWdata[`WTM_F_IAVG -: 3];
					n.pAvgSel = regWdata[`WTM_F_PAVG -: 3];
					n.regTmr = regWdata[`WTM_F_RTMR -: 3];
				end
				`WTM_A_EN: n.enable = regWdata[12:0];
				`WTM_A_MASK: n.pinMask = regWdata[12:0];
				`WTM_A_CLR: clr = 13'h1FFF;
				// direct write-one-to-clear of the status word; this is
				// how the host releases the pin after a bus error
				`WTM_A_STAT: clr = regWdata[12:0];
				`WTM_A_BERR: begin
					if (regWdata[0]) begin
						n.busErrStat = 1'b0;
					end
				end
				default: begin
					if (thrHit) begin
						n.thr[thrIdx] = regWdata[23:0];
					end
				end
			endcase
		end

		//--------------------------------------------------------------
		// averaging windows
		//--------------------------------------------------------------
		for (int k = 0; k < 4; k++) begin
			if (smpStb[k]) begin
				sum = s.acc[k] + 31'(smpVal[k]);
				if (s.cnt[k] + 8'h01 == 8'h01 << smpSel[k]) begin
					n.avg[k] = 24'(sum >> smpSel[k]);
					n.avgNew[k] = 1'b1;
					n.acc[k] = '0;
					n.cnt[k] = '0;
				end else begin
					n.acc[k] = sum;
					n.cnt[k] = s.cnt[k] + 8'h01;
				end
			end
		end
		if (tempStb) begin
			n.extTemp = extTemp;
			n.dieTemp = dieTemp;
			n.tempNew = 1'b1;
		end

		//--------------------------------------------------------------
		// hysteresis flags, re-evaluated on each new result
		//--------------------------------------------------------------
		n.flag[A_GATE] = grpA && ctrlState == WTM_ON && gateLow;
		if (s.avgNew[0]) begin
			if (s.avg[0] <= s.thr[0]) begin
				n.flag[A_INLO] = 1'b1;
			end else if (s.avg[0] > s.thr[0] + `WTM_HYST_V) begin
				n.flag[A_INLO] = 1'b0;
			end
			if (s.avg[0] >= s.thr[1]) begin
				n.flag[A_INHI] = 1'b1;
			end else if (s.avg[0] + `WTM_HYST_V < s.thr[1]) begin
				n.flag[A_INHI] = 1'b0;
			end
		end
		if (s.avgNew[3]) begin
			if (s.avg[3] > s.thr[2]) begin
				n.flag[A_PWR] = 1'b1;
			end else if (s.avg[3] + `WTM_HYST_P < s.thr[2]) begin
				n.flag[A_PWR] = 1'b0;
			end
		end
		if (s.avgNew[1]) begin
			if (s.avg[1] <= s.thr[3]) begin
				n.flag[A_OUTLO] = 1'b1;
			end else if (s.avg[1] > s.thr[3] + `WTM_HYST_V) begin
				n.flag[A_OUTLO] = 1'b0;
			end
			n.flag[A_OUTHI] = s.avg[1] > s.thr[4];
		end
		if (s.avgNew[2]) begin
			if (s.avg[2] > s.thr[5]) begin
				n.flag[A_CURHI] = 1'b1;
			end else if (s.avg[2] + `WTM_HYST_I < s.thr[5]) begin
				n.flag[A_CURHI] = 1'b0;
			end
			// start-up current is low by nature, so wait for it to rise
			if (ctrlState == WTM_ON && s.avg[2] > s.thr[6]) begin
				n.ucArmed = 1'b1;
			end
			if (s.ucArmed && s.avg[2] < s.thr[6]) begin
				n.flag[A_CURLO] = 1'b1;
			end else if (s.avg[2] > s.thr[6] + `WTM_HYST_I) begin
				n.flag[A_CURLO] = 1'b0;
			end
		end
		if (!grpB) begin
			n.ucArmed = 1'b0;
		end
		if (curStb) begin
			if (curNeg && {12'h000, cur} > s.thr[8]) begin
				n.flag[A_REV] = 1'b1;
			end else if (!curNeg || cur == 12'h000) begin
				n.flag[A_REV] = 1'b0;
			end
		end

		// regulation alert: judged once on entry, held for the stay
		n.inIreg = ctrlState == WTM_IREG;
		if (n.inIreg && !s.inIreg) begin
			n.flag[A_REG] = regByOvercurrent && s.regTmr != 3'h0;
		end else if (!n.inIreg) begin
			n.flag[A_REG] = 1'b0;
		end

		if (s.tempNew) begin
			if (24'(s.extTemp) > s.thr[7]) begin
				n.flag[A_TEXT] = 1'b1;
			end else if (24'(s.extTemp) + `WTM_HYST_T < s.thr[7]) begin
				n.flag[A_TEXT] = 1'b0;
			end
			if ($signed(s.dieTemp) > $signed(`WTM_DIE_SET)) begin
				n.flag[A_DIE] = 1'b1;
			end else if ($signed(s.dieTemp) < $signed(`WTM_DIE_CLR)) begin
				n.flag[A_DIE] = 1'b0;
			end
		end
		n.flag[A_BUS] = busFail;

		// state activity windows and enables gate detection
		if (!grpA) begin
			n.flag[A_DIE:A_TEXT] = 2'b00;
			n.flag[A_INHI:A_INLO] = 2'b00;
			n.flag[A_OUTHI] = 1'b0;
		end
		if (!grpB) begin
			n.flag[A_REV:A_REG] = 2'b00;
			n.flag[A_CURLO:A_CURHI] = 2'b00;
			n.flag[A_OUTLO] = 1'b0;
		end
		if (!grpP) begin
			n.flag[A_PWR] = 1'b0;
		end
		n.flag = n.flag & s.enable;

		//--------------------------------------------------------------
		// sticky status; a new event beats a clear in the same cycle
		//--------------------------------------------------------------
		det = s.flag & s.enable;
		if (latched) begin
			det = det & (13'h1 << A_BUS);
			clr = clr & (13'h1 << A_BUS);
		end
		n.status = (s.status & ~clr) | det;
		if (busFail) begin
			n.busErrStat = 1'b1;
		end

		// pin frozen while latched off, so a bus error stays off it
		if (!latched) begin
			// new mask acts at once, so unmasking never lags the status
			n.warnPin = |(n.status & n.pinMask);
		end

		//--------------------------------------------------------------
		// read data and clear-on-read of peak/valley
		//--------------------------------------------------------------
		if (regRd) begin
			unique case (regAddr)
				`WTM_A_CFG: n.rdata = 32'({s.regTmr, 5'h00, s.pAvgSel,
					1'b0, s.iAvgSel, 1'b0, s.vAvgSel});
				`WTM_A_EN: n.rdata = 32'(s.enable);
				`WTM_A_MASK: n.rdata = 32'(s.pinMask);
				`WTM_A_STAT: n.rdata = 32'(s.status);
				`WTM_A_BERR: n.rdata = 32'(s.busErrStat);
				`WTM_A_AVG: n.rdata = 32'(s.avg[0]);
				`WTM_A_AVG + 8'h04: n.rdata = 32'(s.avg[1]);
				`WTM_A_AVG + 8'h08: n.rdata = 32'(s.avg[2]);
				`WTM_A_AVG + 8'h0C: n.rdata = 32'(s.avg[3]);
				`WTM_A_TEMP: n.rdata = 32'(s.extTemp);
				`WTM_A_DIE: n.rdata = 32'(s.dieTemp);
				default: begin
					if (thrHit) begin
						n.rdata = 32'(s.thr[thrIdx]);
					end else if (pvHit) begin
						n.rdata = 32'(s.pv[pvIdx]);
					end
				end
			endcase
		end
		for (int j = 0; j < 9; j++) begin
			base = s.pv[j];
			if (regRd && pvHit && pvIdx == 4'(j)) begin
				base = pvIsPeak[j] ? `WTM_PEAK_RST : `WTM_VALLEY_RST;
			end
			if (pvStb[j]) begin
				if (pvIsPeak[j] ? pvSrc[j] > base : pvSrc[j] < base) begin
					base = pvSrc[j];
				end
			end
			n.pv[j] = base;
		end
	end

	//------------------------------------------------------------------
	// state register
	//------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.enable <= `WTM_EN_RST;
			s.pinMask <= `WTM_MASK_RST;
			s.thr[1] <= `WTM_THR_MAX;
			s.thr[2] <= `WTM_THR_MAX;
			s.thr[4] <= `WTM_THR_MAX;
			s.thr[5] <= `WTM_THR_MAX;
			s.thr[7] <= `WTM_THR_MAX;
			s.thr[8] <= `WTM_THR_MAX;
			s.pv[1] <= `WTM_VALLEY_RST;
			s.pv[3] <= `WTM_VALLEY_RST;
			s.pv[5] <= `WTM_VALLEY_RST;
			s.pv[8] <= `WTM_VALLEY_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	assign regRdata = s.rdata;
	assign warnPin = s.warnPin;

endmodule

/* hw/wtm_pkg.sv */
// types of the warning and telemetry monitor
package wtm_pkg;
	typedef enum logic [2:0] {
		WTM_OTHER = 3'h0,
		WTM_STANDBY = 3'h1,
		WTM_INIT_REG = 3'h2,
		WTM_ON = 3'h3,
		WTM_IREG = 3'h4,
		WTM_FAULT = 3'h5,
		WTM_WAIT = 3'h6,
		WTM_LATCHOFF = 3'h7
	} wtm_ctrl_e;
	typedef struct packed {
		logic [2:0] vAvgSel;
		logic [2:0] iAvgSel;
		logic [2:0] pAvgSel;
		logic [2:0] regTmr;
		logic [12:0] enable;
		logic [12:0] pinMask;
		logic [12:0] status;
		logic [12:0] flag;
		logic busErrStat;
		logic ucArmed;
		logic inIreg;
		logic warnPin;
		logic [11:0] vinRaw;
		logic [8:0][23:0] thr;
		logic [3:0][30:0] acc;
		logic [3:0][7:0] cnt;
		logic [3:0][23:0] avg;
		logic [3:0] avgNew;
		logic [11:0] extTemp;
		logic [7:0] dieTemp;
		logic tempNew;
		logic [8:0][23:0] pv;
		logic [31:0] rdata;
	} wtm_state_s;
endpackage

/* hw/wtm_regs.svh */
// register map, field positions, reset values and limits of the monitor
//------------------------------------------------------------------
// Function
// - in ON, gate-drive-low alert follows gate voltage below 7.8 V.
// - input-low sets at or below threshold, clears above threshold plus 0x60.
// - input-high sets at or above threshold, clears below threshold minus 0x60.
// - power alert sets above threshold, clears below threshold minus 0x100.
// - power alert compares power averaged by the power averaging field.
// - output-low sets at or below threshold, clears above threshold plus 0x60.
// - output-high alert sets when output voltage exceeds its threshold.
// - load-high sets above threshold, clears below threshold minus 0x80.
// - load-low sets below threshold, clears above threshold plus 0x80.
// - load-low detection armed only after current first exceeds its level.
// - regulation alert on entering regulation by overcurrent if timer field nonzero.
// - reverse alert on negative current beyond limit, clears on sample >= 0.
// - external temperature alert clears 25 C below its threshold.
// - die temperature alert sets above 125 C, clears below 115 C.
// - bus failure raises bus error; in latch-off only bus error, no pin.
// - pin follows bus-error bit of alert status; host clears that bit.
// - separate 3-bit averaging fields for voltage, current and power.
// - field value n averages two to the power n samples, 1 to 128.
// - all measurements readable over the register port.
// - status bits stay set until clear-faults, status write-one-to-clear or reset; pin also drops when masked.
// - disabled alert is neither detected nor reported.
// - peaks and valleys clear on read or reset, restart 0x000 / 0xFFF.
//------------------------------------------------------------------
`ifndef WTM_REGS_SVH
`define WTM_REGS_SVH
`define WTM_A_CFG 8'h00
`define WTM_A_EN 8'h04
`define WTM_A_MASK 8'h08
`define WTM_A_STAT 8'h0C
`define WTM_A_CLR 8'h10
`define WTM_A_BERR 8'h14
`define WTM_A_THR 8'h18
`define WTM_A_THR_END 8'h38
`define WTM_A_AVG 8'h40
`define WTM_A_TEMP 8'h50
`define WTM_A_DIE 8'h54
`define WTM_A_PV 8'h58
`define WTM_A_PV_END 8'h78
`define WTM_F_VAVG 2
`define WTM_F_IAVG 6
`define WTM_F_PAVG 10
`define WTM_F_RTMR 18
`define WTM_EN_RST 13'h1FFF
`define WTM_MASK_RST 13'h1FFF
`define WTM_THR_MAX 24'hFFFFFF
`define WTM_PEAK_RST 24'h000000
`define WTM_VALLEY_RST 24'h000FFF
`define WTM_HYST_V 24'h000060
`define WTM_HYST_P 24'h000100
`define WTM_HYST_I 24'h000080
`define WTM_HYST_T 24'h000082
`define WTM_DIE_SET 8'h7D
`define WTM_DIE_CLR 8'h73
`endif
